// ---- design/adc_pipe_pkg.sv ----
// constants for the pipelined converter output timing block
//
// Overview of operation
// RULE1: result is 8-bit straight binary, one step is span over 256.
// RULE2: below negative full scale: range flag high with all-zeros code.
// RULE3: above positive full scale: range flag high with all-ones code.
// RULE4: range flag stays low while the sample lies inside full scale.
// RULE5: while converter clock is high, input is tracked, no conversion starts.
// RULE6: each falling converter clock edge samples and starts a conversion.
// RULE7: result valid at fifth falling edge after sampling, held until next.
// RULE8: once the pipeline is full, one new result per falling edge.
// RULE9: host clocks converter no faster than 20MHz, no slower than 10kHz.
// RULE10: host clock near 50% duty; each phase at least 25ns.
// RULE11: after power-up or 100us clock stop, data invalid for 20 cycles.
// RULE12: power_down_n low powers down amplifiers and bias.
// RULE13: during power-down, data and flag are still driven.
// RULE14: leaving power-down, host discards data for 20 cycles.
// RULE15: range flag carries the same five-cycle latency as its code.
package adc_pipe_pkg;

   // ----------------------------------------------------------------
   // converter geometry and timing
   // ----------------------------------------------------------------
   localparam int unsigned CODE_W        = 8;
   localparam int unsigned LATENCY       = 5;
   localparam int unsigned WARMUP_CYCLES = 20;
   localparam int unsigned CLK_MHZ       = 125;
   localparam int unsigned MIN_PHASE_NS  = 25;
   localparam int unsigned MIN_PHASE_CYC = (MIN_PHASE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STOP_US       = 100;
   localparam int unsigned STOP_CYC      = STOP_US * CLK_MHZ;
   localparam logic [7:0]  CODE_MIN      = 8'h00;
   localparam logic [7:0]  CODE_MAX      = 8'hff;
   localparam logic [7:0]  RESET_CODE    = 8'h00;

endpackage

// ---- design/adc_result_pipe.sv ----
// fixed-latency delay line carrying code and range flag together
`timescale 1ns/1ps
`default_nettype none
module adc_result_pipe #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 5
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   input  wire logic             i_adv,
   input  wire logic [WIDTH-1:0] i_data,
   output var  logic [WIDTH-1:0] o_data
);
   initial begin
      if (DEPTH < 1 || WIDTH < 1) $error("adc_result_pipe: bad geometry");
   end

   logic [WIDTH-1:0] stage      [DEPTH];
   logic [WIDTH-1:0] next_stage [DEPTH];

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         next_stage[i] = stage[i];
      end
      if (i_adv) begin
         next_stage[0] = i_data;
         for (int i = 1; i < DEPTH; i++) begin
            next_stage[i] = stage[i-1];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
               stage[g] <= '0;
            end else if (i_ce) begin
               stage[g] <= next_stage[g];
            end
         end
      end
   endgenerate

   assign o_data = stage[DEPTH-1];
endmodule
`default_nettype wire

// ---- design/adc_output_timing.sv ----
// digital side of the 8-bit pipelined sampling converter
`timescale 1ns/1ps
`default_nettype none
module adc_output_timing #(
   parameter int unsigned CODE_W        = adc_pipe_pkg::CODE_W,
   parameter int unsigned LATENCY       = adc_pipe_pkg::LATENCY,
   parameter int unsigned WARMUP_CYCLES = adc_pipe_pkg::WARMUP_CYCLES,
   parameter int unsigned STOP_CYC      = adc_pipe_pkg::STOP_CYC
) (
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic              i_ce,
   input  wire logic              i_conv_clk,
   input  wire logic              i_power_down_n,
   input  wire logic signed [15:0] i_diff_in,
   input  wire logic signed [15:0] i_full_scale,
   output var  logic [CODE_W-1:0] o_code,
   output var  logic              o_range_exceeded_flag,
   output var  logic              o_bias_on,
   output var  logic              o_data_valid
);
   initial begin
      if (CODE_W != 8) $error("adc_output_timing: code width must be 8");
      if (LATENCY < 1) $error("adc_output_timing: latency must be at least 1");
      if (WARMUP_CYCLES < 1 || WARMUP_CYCLES > 255) $error("adc_output_timing: bad warm-up count");
      if (STOP_CYC < 2) $error("adc_output_timing: bad stop count");
   end

   // ----------------------------------------------------------------
   // quantiser: straight binary over [-fs, +fs], 256 steps
   // ----------------------------------------------------------------
   function automatic logic [CODE_W:0] quantise(input logic signed [15:0] x,
                                                input logic signed [15:0] fs);
      logic signed [31:0] num;
      logic signed [31:0] q;
      num = 32'(x) + 32'(fs);
      q   = 32'sh0;
      if (fs <= 16'sh0) begin
         quantise = {1'b1, adc_pipe_pkg::CODE_MIN};
      end else if (x < -fs) begin
         quantise = {1'b1, adc_pipe_pkg::CODE_MIN}; // RULE2
      end else if (x > fs) begin
         quantise = {1'b1, adc_pipe_pkg::CODE_MAX}; // RULE3
      end else begin
         // half-step rounding places transitions midway between codes
         q = (num * 32'sd256 + 32'(fs)) / (32'sd2 * 32'(fs)); // RULE1
         if (q > 32'sd255) begin
            q = 32'sd255;
         end
         quantise = {1'b0, q[CODE_W-1:0]}; // RULE4
      end
   endfunction

   // ----------------------------------------------------------------
   // converter clock edge detection
   // ----------------------------------------------------------------
   logic conv_clk_d;
   logic next_conv_clk_d;
   logic fall;
   assign next_conv_clk_d = i_conv_clk;
   // only the falling edge starts work; the high phase just tracks
   assign fall = conv_clk_d & ~i_conv_clk; // RULE5 RULE6

   // ----------------------------------------------------------------
   // result pipeline, flag travels with its code
   // ----------------------------------------------------------------
   logic [CODE_W:0] pipe_out;
   logic [CODE_W:0] sample_word;
   assign sample_word = i_power_down_n ? quantise(i_diff_in, i_full_scale)
                                       : {1'b0, adc_pipe_pkg::RESET_CODE};

   // stage 0 loads on the sampling fall itself, so LATENCY stages plus
   // the output flop put the word out on fall LATENCY after sampling
   adc_result_pipe #(
      .WIDTH (CODE_W + 1),
      .DEPTH (LATENCY)
   ) u_pipe (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_adv     (fall & i_power_down_n), // RULE6 RULE8
      .i_data    (sample_word),           // RULE15
      .o_data    (pipe_out)
   );

   // ----------------------------------------------------------------
   // output registers and warm-up tracking
   // ----------------------------------------------------------------
   logic [CODE_W-1:0] next_code;
   logic              next_flag;
   logic              next_bias_on;
   logic              next_valid;
   logic [7:0]        warm_cnt;
   logic [7:0]        next_warm_cnt;
   logic [31:0]       idle_cnt;
   logic [31:0]       next_idle_cnt;

   always_comb begin
      next_code     = o_code;
      next_flag     = o_range_exceeded_flag;
      next_bias_on  = i_power_down_n; // RULE12
      next_warm_cnt = warm_cnt;
      next_idle_cnt = idle_cnt;
      // outputs keep driving the last word while powered down
      if (fall && i_power_down_n) begin
         next_code = pipe_out[CODE_W-1:0]; // RULE7 RULE13
         next_flag = pipe_out[CODE_W];     // RULE15
      end
      if (fall) begin
         next_idle_cnt = 32'h0;
      end else if (idle_cnt < STOP_CYC) begin
         next_idle_cnt = idle_cnt + 32'h1;
      end
      // stopped clock or power-down restarts the warm-up
      if (!i_power_down_n || idle_cnt >= STOP_CYC) begin
         next_warm_cnt = 8'h00; // RULE11 RULE14
      end else if (fall && warm_cnt < 8'(WARMUP_CYCLES)) begin
         next_warm_cnt = warm_cnt + 8'h01;
      end
      next_valid = i_power_down_n && (next_warm_cnt >= 8'(WARMUP_CYCLES));
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         conv_clk_d            <= 1'b0;
         o_code                <= adc_pipe_pkg::RESET_CODE;
         o_range_exceeded_flag <= 1'b0;
         o_bias_on             <= 1'b0;
         o_data_valid          <= 1'b0;
         warm_cnt              <= 8'h00;
         idle_cnt              <= 32'h0;
      end else if (i_ce) begin
         conv_clk_d            <= next_conv_clk_d;
         o_code                <= next_code;
         o_range_exceeded_flag <= next_flag;
         o_bias_on             <= next_bias_on;
         o_data_valid          <= next_valid;
         warm_cnt              <= next_warm_cnt;
         idle_cnt              <= next_idle_cnt;
      end
   end
endmodule
`default_nettype wire

// ---- tb/adc_host_model.sv ----
// host side model that makes the converter clock
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_run,
   input  wire logic [7:0] i_half,
   output var  logic       o_conv_clk
);
   logic [7:0] cnt;
   initial begin
      cnt = 8'h00;
      o_conv_clk = 1'b1;
   end
   // stands still while stopped, so a stop reads as a real gap
   always @(posedge i_sys_clk) begin
      if (i_run && cnt + 8'h01 >= i_half) begin
         cnt <= 8'h00;
         o_conv_clk <= ~o_conv_clk;
      end else if (i_run) begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- tb/adc_output_timing_monitor.sv ----
// concurrent checks on the converter output timing ports
`timescale 1ns/1ps
`default_nettype none
module adc_output_timing_checker #(
   parameter int unsigned CODE_W        = 8,
   parameter int unsigned WARMUP_CYCLES = 20,
   parameter int unsigned STOP_CYC      = 50
) (
   input wire logic               i_sys_clk,
   input wire logic               i_rst,
   input wire logic               i_ce,
   input wire logic               i_conv_clk,
   input wire logic               i_power_down_n,
   input wire logic signed [15:0] i_diff_in,
   input wire logic signed [15:0] i_full_scale,
   input wire logic [CODE_W-1:0]  o_code,
   input wire logic               o_range_exceeded_flag,
   input wire logic               o_bias_on,
   input wire logic               o_data_valid
);
   // ----------------------------------------------------------------
   // reference tracking
   // ----------------------------------------------------------------
   logic       prev;
   logic [4:0] rng_q;
   int         falls;
   int         gap;
   wire logic  fall = prev & ~i_conv_clk & i_ce & i_power_down_n;
   wire logic  rng = i_diff_in > i_full_scale || i_diff_in < -i_full_scale;
   always_ff @(posedge i_sys_clk) begin
      prev <= i_conv_clk;
      rng_q <= i_rst ? 5'h00 : fall ? {rng_q[3:0], rng} : rng_q;
      // a stopped clock restarts the warm-up count, as power-down does
      falls <= (i_rst || !i_power_down_n || gap >= STOP_CYC) ? 0 : falls + int'(fall && falls < 99);
      gap <= (i_rst || fall) ? 0 : gap + int'(gap < 999);
   end
   default clocking dc @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   property p_hold; !fall |=> $stable({o_code, o_range_exceeded_flag}); endproperty
   a_hold: assert property (p_hold) else $error("result moved without a fall");
   property p_lat; fall |=> o_range_exceeded_flag == $past(rng_q[4]); endproperty
   a_lat: assert property (p_lat) else $error("flag not five falls behind");
   property p_ends; o_range_exceeded_flag |-> o_code == 8'h00 || o_code == 8'hff; endproperty
   a_ends: assert property (p_ends) else $error("flag with mid code");
   property p_bias_off; !i_power_down_n |=> !o_bias_on; endproperty
   a_bias_off: assert property (p_bias_off) else $error("bias on in power-down");
   property p_bias_on; $rose(i_power_down_n) |=> o_bias_on; endproperty
   a_bias_on: assert property (p_bias_on) else $error("bias not restored");
   property p_pd_hold; !i_power_down_n [*3] |-> $stable(o_code) && !o_data_valid; endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("power-down output wrong");
   property p_warm; $rose(o_data_valid) |-> falls >= WARMUP_CYCLES; endproperty
   a_warm: assert property (p_warm) else $error("valid before warm-up");
   property p_gap; gap > STOP_CYC + 2 |-> !o_data_valid; endproperty
   a_gap: assert property (p_gap) else $error("valid after clock stop");
   c_over: cover property (fall && rng);
   c_warm: cover property ($rose(o_data_valid));
   c_pd: cover property ($fell(i_power_down_n));
endmodule
bind adc_output_timing adc_output_timing_checker #(.CODE_W(CODE_W), .WARMUP_CYCLES(WARMUP_CYCLES),
   .STOP_CYC(STOP_CYC)) u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_conv_clk(i_conv_clk),
   .i_power_down_n(i_power_down_n), .i_diff_in(i_diff_in), .i_full_scale(i_full_scale), .o_code(o_code),
   .o_range_exceeded_flag(o_range_exceeded_flag), .o_bias_on(o_bias_on), .o_data_valid(o_data_valid));
`default_nettype wire

// ---- tb/test_pipelined_adc_output_timing.sv ----
// self-checking bench for the converter output timing block
`timescale 1ns/1ps
`default_nettype none
module test_pipelined_adc_output_timing;
   localparam int FS = 128;
   logic               clk;
   logic               rst;
   logic               pdn;
   logic               run;
   logic               conv_clk;
   logic signed [15:0] diff;
   logic [7:0]         code;
   logic               flag;
   logic               bias;
   logic               valid;
   logic [8:0]         exp_q[$];
   logic [8:0]         hold;
   int                 bad_count;
   int                 n_compared;
   adc_host_model u_host (.i_sys_clk(clk), .i_run(run), .i_half(8'h04), .o_conv_clk(conv_clk));
   adc_output_timing #(.STOP_CYC(50)) u_dut (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_conv_clk(conv_clk),
      .i_power_down_n(pdn), .i_diff_in(diff), .i_full_scale(16'sh0080), .o_code(code),
      .o_range_exceeded_flag(flag), .o_bias_on(bias), .o_data_valid(valid));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [8:0] got, input logic [8:0] want);
      n_compared++;
      if (got !== want) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   function automatic logic [8:0] enc(input int x);
      if (x < -FS) return 9'h100;
      if (x > FS) return 9'h1ff;
      return (x + FS > 255) ? 9'h0ff : 9'((x * 256 + FS * 257) / (2 * FS));
   endfunction
   task automatic step(input int x);
      @(negedge conv_clk);
      diff <= 16'(x);
      @(posedge clk);
      #1;
      exp_q.push_back(enc(x));
      check({flag, code}, exp_q.pop_front());
   endtask
   task automatic t_warm();
      repeat (19) step(0);
      check({7'h00, bias, valid}, 9'h002);
      repeat (3) step(0);
      check({7'h00, bias, valid}, 9'h003);
   endtask
   task automatic t_convert();
      int vals [10] = '{-300, -129, -128, -1, 0, 1, 127, 128, 129, 300};
      foreach (vals[i]) step(vals[i]);
      repeat (5) step(0);
   endtask
   task automatic t_pd();
      // taken while settled, away from any edge
      hold = {flag, code};
      @(posedge clk);
      pdn <= 1'b0;
      repeat (4) @(negedge conv_clk);
      @(posedge clk);
      #1;
      check({flag, code}, hold);
      check({7'h00, bias, valid}, 9'h000);
      @(posedge clk);
      pdn <= 1'b1;
      t_warm();
   endtask
   task automatic t_gap();
      @(posedge clk);
      run <= 1'b0;
      repeat (80) @(posedge clk);
      #1;
      check({8'h00, valid}, 9'h000);
      @(posedge clk);
      run <= 1'b1;
      t_warm();
   endtask
   task automatic conclude();
      if (bad_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // generous bound: the sequence needs under a thousand cycles
   initial begin
      #40000;
      bad_count++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      pdn = 1'b1;
      run = 1'b0;
      diff = 16'sh0000;
      bad_count = 0;
      n_compared = 0;
      repeat (5) exp_q.push_back(9'h000);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      run <= 1'b1;
      t_warm();
      t_convert();
      t_pd();
      t_gap();
      conclude();
   end
endmodule
`default_nettype wire
